// ### cmrs_fifo.sv
// cmrs_fifo: small valid/ready fifo in the receive byte path.
// assumes both sides on clk_sys_in; synchronous active-low reset.
`timescale 1ns/1ps
module cmrs_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output      logic             in_ready_out,
   output      logic [WIDTH-1:0] out_data_out,
   output      logic             out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // refused at elaboration: the pointer arithmetic needs a power of two
   if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_size
      $error("fifo width below 1 or depth not a power of two above 1");
   end

   typedef struct packed
   {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } cmrs_fifo_st_t;

   cmrs_fifo_st_t    st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push, pop;

   assign in_ready_out  = (st_reg.wr - st_reg.rd) != (AW+1)'(DEPTH);
   assign out_valid_out = st_reg.wr != st_reg.rd;
   assign out_data_out  = mem[st_reg.rd[AW-1:0]];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;

   always_comb
   begin
      st_next = st_reg;
      if (push)
         st_next.wr = st_reg.wr + 1'b1;
      if (pop)
         st_next.rd = st_reg.rd + 1'b1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         st_reg <= '0;
      else
         st_reg <= st_next;
      if (push)
         mem[st_reg.wr[AW-1:0]] <= in_data_in;
   end
endmodule // cmrs_fifo

// ### cmrs_mem_model.sv
// cmrs_mem_model: buffer-memory port that takes byte0 words.
// assumes words come on clk_sys_in by valid/ready; keeps them in order.
`timescale 1ns/1ps
module cmrs_mem_model
(
   input  wire logic       clk_sys_in,
   input  wire logic       reset_n_in,
   input  wire logic       hold_in,
   input  wire logic       slow_in,
   input  wire logic [7:0] byte0_data_in,
   input  wire logic       byte0_valid_in,
   output      logic       byte0_ready_out,
   input  wire logic       cpu_wr_in,
   input  wire logic [7:0] cpu_data_in,
   output      logic [7:0] byte0_out
);
   logic [7:0] words[$];
   logic       phase_reg;
   logic [7:0] byte0_reg;

   // only the memory port itself stalls the dma, never a cpu read
   assign byte0_ready_out = !hold_in && (!slow_in || phase_reg);
   assign byte0_out       = byte0_reg;

   always @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         phase_reg <= 1'b0;
         byte0_reg <= 8'h00;
         words.delete();
      end
      else
      begin
         phase_reg <= !phase_reg;
         // a dma word always beats a cpu write in the same cycle
         if (byte0_valid_in && byte0_ready_out)
         begin
            words.push_back(byte0_data_in);
            byte0_reg <= byte0_data_in;
         end
         else if (cpu_wr_in)
            byte0_reg <= cpu_data_in;
      end
   end
endmodule // cmrs_mem_model

// ### cmrs_object.sv
// cmrs_object: one message object's rtr handling, object enable control,
// receive-buffer semaphore writes and fragment header decode.
// assumes the can core, pre-arbiter and memory arbiter are on clk_sys_in;
// buffer writes leave through a 4-deep fifo and may be stalled.
//
// Contract
// - rx rtr object accepts matching remote frame
// - accepted remote frame raises interrupt if enabled
// - tx rtr object sends rtr bit one
// - rtr sent: clear enable, interrupt if enabled
// - matching frame during pending rtr clears enable
// - lock bits sit at byte0 bits 5,4
// - start of frame writes 01h to byte0
// - end of frame writes info, bits 5,4 set
// - fragmented: 00h at start, count at end
// - dma never blocked by cpu reads
// - enable cleared in pre-arbitration drops message
// - enable clear ignored during transmission
// - devicenet fragment type 00/01/10, 3F single
// - canopen segment bit 0 marks last
// - auto ack byte low nibble 0000
// - protocol select 00 can,01 dnet,10 copen,11 osek
`timescale 1ns/1ps
module cmrs_object
(
   input  wire logic       clk_sys_in,
   input  wire logic       reset_n_in,
   // object configuration
   input  wire logic       obj_is_tx_in,
   input  wire logic [7:0] object_control_reg_in,
   input  wire logic       int_enable_in,
   input  wire logic       protocol_select_hi_in,
   input  wire logic       protocol_select_lo_in,
   input  wire logic       sw_set_enable_in,
   input  wire logic       sw_clear_enable_in,
   output      logic       object_enable_out,
   // pre-arbitration and can core
   input  wire logic       prearb_win_in,
   input  wire logic       tx_start_in,
   input  wire logic       tx_done_ok_in,
   input  wire logic       tx_lost_in,
   output      logic       tx_request_out,
   output      logic       tx_rtr_bit_out,
   input  wire logic       rx_id_match_in,
   input  wire logic       rx_is_remote_in,
   input  wire logic       rx_frame_start_in,
   input  wire logic       rx_frame_end_in,
   input  wire logic       rx_fragmented_in,
   input  wire logic [7:0] rx_frame_info_in,
   input  wire logic [7:0] rx_byte_count_in,
   input  wire logic [7:0] rx_first_data_in,
   output      logic       rx_accept_out,
   output      logic       complete_pulse_out,
   output      logic       complete_irq_out,
   // byte0 writes toward buffer memory
   output      logic [7:0] byte0_data_out,
   output      logic       byte0_valid_out,
   input  wire logic       byte0_ready_in,
   output      logic       byte0_stall_out,
   // fragment header decode
   output      logic       frag_first_out,
   output      logic       frag_middle_out,
   output      logic       frag_last_out,
   output      logic       frag_single_out,
   output      logic       copen_last_seg_out,
   output      logic [7:0] ack_byte1_out,
   input  wire logic [2:0] server_cmd_spec_in,
   input  wire logic       ack_toggle_in
);
   typedef struct packed
   {
      cmrs_pkg::cmrs_tx_state_t tx;
      logic                     en;
      logic                     done;
      logic                     irq;
      logic                     accept;
      logic                     ff_last;
      logic                     ff_single;
      logic                     ff_first;
      logic                     ff_mid;
      logic                     co_last;
      logic [7:0]               ack;
   } cmrs_obj_st_t;

   cmrs_obj_st_t st_reg, st_next;
   logic         rtr_mode;
   logic [1:0]   proto;
   logic [7:0]   f_data;
   logic         f_valid;
   logic         f_ready;

   assign rtr_mode = object_control_reg_in[cmrs_pkg::CTL_RTR_BIT];
   assign proto    = {protocol_select_hi_in, protocol_select_lo_in};

   // ----------------------------------------------------------------
   // byte0 write generation
   // ----------------------------------------------------------------
   // the write is offered regardless of any cpu activity on the buffer;
   // a dropped start write would hide the update from the cpu.
   always_comb
   begin
      f_data  = cmrs_pkg::BYTE0_RESET;
      f_valid = 1'b0;
      if (!obj_is_tx_in && st_reg.en && rx_id_match_in)
      begin
         if (rx_frame_start_in)
         begin
            f_valid = 1'b1;
            f_data  = rx_fragmented_in ? cmrs_pkg::BYTE0_FRAG
                                       : cmrs_pkg::BYTE0_BUSY;
         end
         // mask covers LOCK_HI_BIT and LOCK_LO_BIT
         else if (rx_frame_end_in)
         begin
            f_valid = 1'b1;
            f_data  = rx_fragmented_in ? rx_byte_count_in
                    : (rx_frame_info_in | cmrs_pkg::LOCK_MASK);
         end
      end
   end

   // no read-modify-write: byte0 is always replaced outright
   cmrs_fifo #(.WIDTH(8), .DEPTH(cmrs_pkg::FIFO_DEPTH)) u_fifo
   (
      .clk_sys_in    (clk_sys_in),
      .reset_n_in    (reset_n_in),
      .in_data_in    (f_data),
      .in_valid_in   (f_valid),
      .in_ready_out  (f_ready),
      .out_data_out  (byte0_data_out),
      .out_valid_out (byte0_valid_out),
      .out_ready_in  (byte0_ready_in)
   );
   // the core must hold the frame while the fifo is full
   assign byte0_stall_out = !f_ready;

   // ----------------------------------------------------------------
   // enable and transmit sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next        = st_reg;
      st_next.done   = 1'b0;
      st_next.accept = 1'b0;
      if (sw_set_enable_in)
         st_next.en = 1'b1;
      // clear honoured only outside transmission
      if (sw_clear_enable_in && st_reg.tx != cmrs_pkg::CMRS_TX_SEND)
         st_next.en = 1'b0;
      case (st_reg.tx)
         cmrs_pkg::CMRS_TX_IDLE:
            if (obj_is_tx_in && st_reg.en)
               st_next.tx = cmrs_pkg::CMRS_TX_PRE;
         cmrs_pkg::CMRS_TX_PRE:
            if (!st_next.en)
               st_next.tx = cmrs_pkg::CMRS_TX_IDLE;
            else if (prearb_win_in && tx_start_in)
               st_next.tx = cmrs_pkg::CMRS_TX_SEND;
         cmrs_pkg::CMRS_TX_SEND:
            if (tx_done_ok_in)
            begin
               st_next.tx   = cmrs_pkg::CMRS_TX_IDLE;
               st_next.en   = 1'b0;
               st_next.done = 1'b1;
               st_next.irq  = int_enable_in;
            end
            else if (tx_lost_in)
               st_next.tx = cmrs_pkg::CMRS_TX_PRE;
         default:
            st_next.tx = cmrs_pkg::CMRS_TX_IDLE;
      endcase
      // a matching frame cancels a pending remote request silently
      if (obj_is_tx_in && rtr_mode && st_reg.en && rx_id_match_in
          && rx_frame_end_in && st_reg.tx != cmrs_pkg::CMRS_TX_IDLE)
      begin
         st_next.tx   = cmrs_pkg::CMRS_TX_IDLE;
         st_next.en   = 1'b0;
         st_next.done = 1'b0;
         st_next.irq  = 1'b0;
      end
      // receive side completion, remote frames only accepted in rtr mode
      if (!obj_is_tx_in && st_reg.en && rx_id_match_in && rx_frame_end_in
          && (!rx_is_remote_in || rtr_mode))
      begin
         st_next.accept = rx_is_remote_in;
         st_next.done   = 1'b1;
         st_next.irq    = int_enable_in;
      end
      else if (!st_next.done)
         st_next.irq = 1'b0;
      // fragment header decode, byte 1 of the frame
      st_next.ff_first  = proto == cmrs_pkg::PROTO_DNET
                          && rx_first_data_in[7:6] == cmrs_pkg::FRAG_FIRST;
      st_next.ff_mid    = proto == cmrs_pkg::PROTO_DNET
                          && rx_first_data_in[7:6] == cmrs_pkg::FRAG_MIDDLE;
      st_next.ff_last   = proto == cmrs_pkg::PROTO_DNET
                          && rx_first_data_in[7:6] == cmrs_pkg::FRAG_LAST;
      st_next.ff_single = proto == cmrs_pkg::PROTO_DNET
                          && rx_first_data_in == cmrs_pkg::FRAG_SINGLE;
      st_next.co_last   = proto == cmrs_pkg::PROTO_COPEN
                          && rx_first_data_in[0];
      st_next.ack       = {server_cmd_spec_in, ack_toggle_in,
                           cmrs_pkg::ACK_LOW_NIBBLE};
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign object_enable_out  = st_reg.en;
   assign tx_request_out     = st_reg.tx == cmrs_pkg::CMRS_TX_PRE;
   assign tx_rtr_bit_out     = st_reg.tx == cmrs_pkg::CMRS_TX_SEND
                               && rtr_mode;
   assign rx_accept_out      = st_reg.accept;
   assign complete_pulse_out = st_reg.done;
   assign complete_irq_out   = st_reg.irq;
   assign frag_first_out     = st_reg.ff_first;
   assign frag_middle_out    = st_reg.ff_mid;
   assign frag_last_out      = st_reg.ff_last;
   assign frag_single_out    = st_reg.ff_single;
   assign copen_last_seg_out = st_reg.co_last;
   assign ack_byte1_out      = st_reg.ack;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_tx_ok;
      st_reg.tx == cmrs_pkg::CMRS_TX_SEND && tx_done_ok_in;
   endsequence

   a_tx_done_clears: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (s_tx_ok and !sw_set_enable_in) |=> !object_enable_out
      && complete_pulse_out)
      else $error("enable not cleared after tx");
   a_tx_irq_gate: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (s_tx_ok and !rx_frame_end_in)
      |=> complete_irq_out == $past(int_enable_in))
      else $error("tx irq gating wrong");
   a_clear_ignored: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      st_reg.tx == cmrs_pkg::CMRS_TX_SEND && object_enable_out
      && !tx_done_ok_in && !rx_frame_end_in |=> object_enable_out)
      else $error("enable cleared during tx");
   a_pre_drop: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      tx_request_out && sw_clear_enable_in && !sw_set_enable_in
      |=> !object_enable_out ##1 !tx_request_out)
      else $error("pending message not dropped");
   a_rtr_cancel: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      obj_is_tx_in && rtr_mode && object_enable_out && rx_id_match_in
      && rx_frame_end_in && st_reg.tx != cmrs_pkg::CMRS_TX_IDLE
      && !sw_set_enable_in
      |=> !object_enable_out && !complete_irq_out)
      else $error("rtr cancel wrong");
   a_rx_remote: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      !obj_is_tx_in && rtr_mode && object_enable_out && rx_id_match_in
      && rx_frame_end_in && rx_is_remote_in |=> rx_accept_out)
      else $error("remote frame not accepted");
   a_rx_irq: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      rx_accept_out |-> complete_irq_out == $past(int_enable_in))
      else $error("rx irq gating wrong");
   a_start_busy: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      f_valid && f_ready && rx_frame_start_in && !rx_fragmented_in
      |-> f_data == cmrs_pkg::BYTE0_BUSY)
      else $error("start byte not 01h");
   a_end_locks: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      f_valid && rx_frame_end_in && !rx_fragmented_in
      |-> f_data[cmrs_pkg::LOCK_HI_BIT] && f_data[cmrs_pkg::LOCK_LO_BIT])
      else $error("lock bits not set");
   a_ack_nibble: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      ##1 ack_byte1_out[3:0] == cmrs_pkg::ACK_LOW_NIBBLE)
      else $error("ack low nibble not zero");
   a_rtr_bit_send: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      tx_request_out && rtr_mode && prearb_win_in && tx_start_in
      && !sw_clear_enable_in && !(rx_id_match_in && rx_frame_end_in)
      |=> tx_rtr_bit_out)
      else $error("rtr bit not sent");
   a_frag_start: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      f_valid && rx_frame_start_in && rx_fragmented_in
      |-> f_data == cmrs_pkg::BYTE0_FRAG)
      else $error("fragment start byte not 00h");
   a_word_queued: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      f_valid && f_ready |=> byte0_valid_out)
      else $error("byte0 word not queued");
   a_remote_ignored: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      !obj_is_tx_in && !rtr_mode && rx_is_remote_in && rx_frame_end_in
      |=> !rx_accept_out && !complete_pulse_out)
      else $error("remote frame taken without rtr mode");
endmodule // cmrs_object

// ### cmrs_object_tb_top.sv
// cmrs_object_tb_top: directed bench for one message object.
// assumes the memory model above on the byte0 port; bench plays the core.
`timescale 1ns/1ps
module cmrs_object_tb_top;
   logic       clk_sys_in, reset_n_in, is_tx, int_en, p_hi, p_lo;
   logic       set_en, clr_en, win, t_start, t_ok, t_lost, id_m, remote;
   logic       r_start, r_end, frag, hold, slow, tgl, rdy;
   logic [7:0] ctl, info, first;
   logic [2:0] scs;
   logic       en, req, rtr, acc, cpl, irq, vld, stall, ff, fm, fl, fs, cl;
   logic [7:0] b0, ack;
   logic [7:0] exp_q[$];
   logic       sw_wr;
   logic [7:0] sw_dat, sem_b0;
   logic [7:0] frag_pat[4] = '{8'h00, 8'h41, 8'h85, 8'h3F};
   int         n_errors, n_tests, n_cpl, n_irq, n_acc, k;

   cmrs_object uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .obj_is_tx_in(is_tx), .object_control_reg_in(ctl),
      .int_enable_in(int_en), .protocol_select_hi_in(p_hi),
      .protocol_select_lo_in(p_lo), .sw_set_enable_in(set_en),
      .sw_clear_enable_in(clr_en), .object_enable_out(en),
      .prearb_win_in(win), .tx_start_in(t_start), .tx_done_ok_in(t_ok),
      .tx_lost_in(t_lost), .tx_request_out(req), .tx_rtr_bit_out(rtr),
      .rx_id_match_in(id_m), .rx_is_remote_in(remote),
      .rx_frame_start_in(r_start), .rx_frame_end_in(r_end),
      .rx_fragmented_in(frag), .rx_frame_info_in(info),
      .rx_byte_count_in(info), .rx_first_data_in(first),
      .rx_accept_out(acc), .complete_pulse_out(cpl), .complete_irq_out(irq),
      .byte0_data_out(b0), .byte0_valid_out(vld), .byte0_ready_in(rdy),
      .byte0_stall_out(stall), .frag_first_out(ff), .frag_middle_out(fm),
      .frag_last_out(fl), .frag_single_out(fs), .copen_last_seg_out(cl),
      .ack_byte1_out(ack), .server_cmd_spec_in(scs), .ack_toggle_in(tgl));

   cmrs_mem_model mem (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .hold_in(hold), .slow_in(slow), .byte0_data_in(b0),
      .byte0_valid_in(vld), .byte0_ready_out(rdy), .cpu_wr_in(sw_wr),
      .cpu_data_in(sw_dat), .byte0_out(sem_b0));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = !clk_sys_in;
   end

   always @(posedge clk_sys_in)
   begin
      if (cpl === 1'b1) n_cpl++;
      if (irq === 1'b1) n_irq++;
      if (acc === 1'b1) n_acc++;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want)
      begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   task automatic cmp1(input logic got, input logic want);
      cmp8({7'h00, got}, {7'h00, want});
   endtask

   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic clr_cnt();
      n_cpl = 0;
      n_irq = 0;
      n_acc = 0;
   endtask

   // one start or end strobe from the core, taken at the next edge
   task automatic rx_evt(input logic is_end, input logic [7:0] val);
      info = val;
      if (is_end) r_end = 1'b1;
      else r_start = 1'b1;
      step(1);
      r_end = 1'b0;
      r_start = 1'b0;
   endtask

   task automatic pulse_en(input logic set);
      if (set) set_en = 1'b1;
      else clr_en = 1'b1;
      step(1);
      set_en = 1'b0;
      clr_en = 1'b0;
   endtask

   task automatic check_words();
      int w;
      w = 0;
      while (mem.words.size() < exp_q.size() && w < 200)
      begin
         step(1);
         w++;
      end
      if (w == 200)
      begin
         n_errors++;
         stop_test();
      end
      while (exp_q.size() > 0)
         cmp8(mem.words.pop_front(), exp_q.pop_front());
   endtask

   initial
   begin
      #(40 * 20000);
      n_errors++;
      stop_test();
   end

   initial
   begin
      {is_tx, int_en, p_hi, p_lo, set_en, clr_en, win, t_start} = 8'h00;
      {t_ok, t_lost, id_m, remote, r_start, r_end, frag, hold} = 8'h00;
      {slow, tgl, ctl, info, first, scs} = 29'h0000000;
      sw_wr = 1'b0;
      sw_dat = 8'h00;
      n_errors = 0;
      n_tests = 0;
      clr_cnt();
      reset_n_in = 1'b0;
      step(20);
      reset_n_in = 1'b1;
      cmp1(en, 1'b0);
      cmp1(vld, 1'b0);
      // ----------------------------------------------------------------
      // receive path: byte0 words, completion and lock bits
      // ----------------------------------------------------------------
      int_en = 1'b1;
      id_m = 1'b1;
      pulse_en(1'b1);
      cmp1(en, 1'b1);
      rx_evt(1'b0, 8'h48);
      exp_q.push_back(cmrs_pkg::BYTE0_BUSY);
      rx_evt(1'b1, 8'h48);
      exp_q.push_back(8'h48 | cmrs_pkg::LOCK_MASK);
      int_en = 1'b0;
      rx_evt(1'b0, 8'h05);
      exp_q.push_back(cmrs_pkg::BYTE0_BUSY);
      rx_evt(1'b1, 8'h05);
      exp_q.push_back(8'h35);
      check_words();
      cmp8(8'(n_cpl), 8'h02);
      cmp8(8'(n_irq), 8'h01);
      // software marks the buffer, then a new frame lands over the mark
      cmp8(sem_b0, 8'h35);
      sw_dat = (sem_b0 & ~cmrs_pkg::LOCK_MASK) | 8'h20;
      sw_wr = 1'b1;
      step(1);
      sw_wr = 1'b0;
      cmp8(sem_b0 & cmrs_pkg::LOCK_MASK, 8'h20);
      rx_evt(1'b0, 8'h09);
      exp_q.push_back(cmrs_pkg::BYTE0_BUSY);
      check_words();
      cmp8(sem_b0, cmrs_pkg::BYTE0_BUSY);
      rx_evt(1'b1, 8'h09);
      exp_q.push_back(8'h39);
      check_words();
      cmp8(sem_b0 & cmrs_pkg::LOCK_MASK, 8'h30);
      frag = 1'b1;
      rx_evt(1'b0, 8'h11);
      exp_q.push_back(cmrs_pkg::BYTE0_FRAG);
      rx_evt(1'b1, 8'hFF);
      exp_q.push_back(8'hFF);
      check_words();
      frag = 1'b0;
      // ----------------------------------------------------------------
      // remote frames: ignored without rtr mode, accepted with it
      // ----------------------------------------------------------------
      remote = 1'b1;
      int_en = 1'b1;
      for (k = 0; k < 2; k++)
      begin
         ctl = 8'(k);
         clr_cnt();
         rx_evt(1'b0, 8'h40);
         rx_evt(1'b1, 8'h40);
         step(3);
         cmp8(8'(n_acc), 8'(k));
         cmp1(n_irq > 0, k == 1);
      end
      remote = 1'b0;
      ctl = 8'h00;
      step(10);
      mem.words.delete();
      // ----------------------------------------------------------------
      // fill the fifo against a stalled memory, then drain it slowly
      // ----------------------------------------------------------------
      hold = 1'b1;
      for (k = 0; k < 8 && stall !== 1'b1; k++)
      begin
         rx_evt(k[0], 8'(k));
         exp_q.push_back(k[0] ? 8'(k) | 8'h30 : cmrs_pkg::BYTE0_BUSY);
         step(1);
      end
      cmp1(stall, 1'b1);
      hold = 1'b0;
      slow = 1'b1;
      check_words();
      cmp1(stall, 1'b0);
      slow = 1'b0;
      // ----------------------------------------------------------------
      // transmit rtr object: drop, lost, ignored clear, done
      // ----------------------------------------------------------------
      is_tx = 1'b1;
      ctl = 8'h01;
      id_m = 1'b0;
      pulse_en(1'b1);
      step(1);
      cmp1(req, 1'b1);
      pulse_en(1'b0);
      step(1);
      cmp1(en, 1'b0);
      cmp1(req, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         int_en = k[0];
         pulse_en(1'b1);
         step(1);
         {win, t_start} = 2'b11;
         step(1);
         {win, t_start} = 2'b00;
         cmp1(rtr, 1'b1);
         t_lost = 1'b1;
         step(1);
         t_lost = 1'b0;
         step(1);
         cmp1(req, 1'b1);
         {win, t_start} = 2'b11;
         step(1);
         {win, t_start} = 2'b00;
         pulse_en(1'b0);
         cmp1(en, 1'b1);
         clr_cnt();
         t_ok = 1'b1;
         step(1);
         t_ok = 1'b0;
         step(2);
         cmp1(en, 1'b0);
         cmp8(8'(n_cpl), 8'h01);
         cmp8(8'(n_irq), 8'(k));
      end
      for (k = 0; k < 2; k++)
      begin
         pulse_en(1'b1);
         step(1);
         if (k == 1)
         begin
            {win, t_start} = 2'b11;
            step(1);
            {win, t_start} = 2'b00;
         end
         clr_cnt();
         id_m = 1'b1;
         rx_evt(1'b0, 8'h00);
         rx_evt(1'b1, 8'h00);
         step(2);
         id_m = 1'b0;
         cmp1(en, 1'b0);
         cmp8(8'(n_irq), 8'h00);
      end
      // ----------------------------------------------------------------
      // first-byte decode and ack byte under every protocol code
      // ----------------------------------------------------------------
      is_tx = 1'b0;
      {p_hi, p_lo} = cmrs_pkg::PROTO_DNET;
      for (k = 0; k < 4; k++)
      begin
         first = frag_pat[k];
         step(2);
         cmp1(ff, first[7:6] == 2'b00);
         cmp1(fm, first == 8'h41);
         if (first != 8'h3F)
            cmp1(fl, first == 8'h85);
         cmp1(fs, first == 8'h3F);
      end
      {p_hi, p_lo} = cmrs_pkg::PROTO_COPEN;
      for (k = 0; k < 2; k++)
      begin
         first = 8'hC0 | 8'(k);
         step(2);
         cmp1(cl, k[0]);
      end
      scs = 3'h5;
      tgl = 1'b1;
      for (k = 0; k < 4; k++)
      begin
         {p_hi, p_lo} = 2'(k);
         step(2);
         cmp8(ack, {3'h5, 1'b1, cmrs_pkg::ACK_LOW_NIBBLE});
         cmp1(cl, k == 2);
      end
      stop_test();
   end
endmodule // cmrs_object_tb_top

// ### cmrs_pkg.sv
// cmrs_pkg: shared constants for the message-object rtr / semaphore block.
// assumes a single 25 MHz system clock; no bus, everything on plain ports.
package cmrs_pkg;

   // ----------------------------------------------------------------
   // object control and frame info
   // ----------------------------------------------------------------
   localparam int        CTL_RTR_BIT     = 0;
   localparam int        LOCK_HI_BIT     = 5;
   localparam int        LOCK_LO_BIT     = 4;
   localparam logic [7:0] BYTE0_BUSY     = 8'h01;
   localparam logic [7:0] BYTE0_FRAG     = 8'h00;
   localparam logic [7:0] LOCK_MASK      = 8'h30;
   localparam logic [7:0] FRAG_SINGLE    = 8'h3F;

   // ----------------------------------------------------------------
   // protocol selection and fragment types
   // ----------------------------------------------------------------
   localparam logic [1:0] PROTO_CAN      = 2'h0;
   localparam logic [1:0] PROTO_DNET     = 2'h1;
   localparam logic [1:0] PROTO_COPEN    = 2'h2;
   localparam logic [1:0] PROTO_OSEK     = 2'h3;
   localparam logic [1:0] FRAG_FIRST     = 2'h0;
   localparam logic [1:0] FRAG_MIDDLE    = 2'h1;
   localparam logic [1:0] FRAG_LAST      = 2'h2;
   localparam logic [3:0] ACK_LOW_NIBBLE = 4'h0;

   // ----------------------------------------------------------------
   // reset values and sizes
   // ----------------------------------------------------------------
   localparam int        FIFO_DEPTH      = 4;
   localparam logic [7:0] BYTE0_RESET    = 8'h00;

   typedef enum logic [1:0]
   {
      CMRS_TX_IDLE = 2'b00,
      CMRS_TX_PRE  = 2'b01,
      CMRS_TX_SEND = 2'b10
   } cmrs_tx_state_t;

endpackage
